// [include/smft_pkg.sv]
// package for the smbus target front end with staged fan configuration
// assumes a 100 mhz core clock; all constants are read as smft_pkg::name
package smft_pkg;
   // core clock period in ns
   localparam int CLK_PERIOD_NS = 10;
   // stuck-bus window, least figure in ms, rounded up to cycles
   localparam int TIMEOUT_MIN_MS = 25;
   localparam int TIMEOUT_MAX_MS = 35;
   localparam int TIMEOUT_CYC = (TIMEOUT_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // power-on delay, longest figure, rounded down
   localparam int POR_MS = 500;
   localparam int POR_CYC = (POR_MS * 1000000) / CLK_PERIOD_NS;
   // target addresses
   localparam logic [6:0] ADDR_DEFAULT = 7'h2e;
   localparam logic [6:0] ADDR_SEL_LOW = 7'h2c;
   localparam logic [6:0] ADDR_SEL_HIGH = 7'h2d;
   localparam logic [4:0] ADDR_PREFIX = 5'h0b;
   // register map
   localparam logic [7:0] REG_CTRL = 8'h40;
   localparam logic [7:0] FAN_FIRST = 8'h5c;
   localparam logic [7:0] FAN_LAST = 8'h6e;
   localparam int FAN_COUNT = 19;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_LOCK_BIT = 1;
   localparam logic [7:0] FAN_RESET = 8'h00;
   // bus engine states
   typedef enum logic [4:0] {
      SM_IDLE = 5'b00001,
      SM_ADDR = 5'b00010,
      SM_ACK = 5'b00100,
      SM_DATA = 5'b01000,
      SM_SEND = 5'b10000
   } smft_state_type;
endpackage

// [rtl/smft_sync.sv]
// two-flop synchroniser for one bit from outside the core clock
// assumes nothing but core_clk_in, rst_n_in and the ce_in enable
`timescale 1ns/10ps
module smft_sync (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic d_in,
   output logic q_out
);
   logic meta_reg; // first stage, read only by q_out
   // both stages idle high like a pulled-up line
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_reg <= 1'b1;
         q_out <= 1'b1;
      end else if (ce_in) begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end
endmodule

// [rtl/smft_top.sv]
// smbus target front end: address straps, stuck-bus timeout, staged fan config
// assumes open-drain scl/sda and straps resolved outside; pins are asynchronous
// Summary of operation
// - bus low past timeout resets engine, releases data
// - operational within 500 ms after reset
// - fan drive 3 pin powers up as strap input
// - strap high locks default address 2eh
// - strap low picks 2ch or 2dh by select
// - latch only on first prefix-matching transaction
// - fan drive 3 stays high until first transaction
// - shared pins resume fan use after first transaction at 2eh only
// - non-default address disables tach 4, drive 3
// - strap high later reverts to 2eh after five bits
// - staged writes not applied until start flag set
// - start applies registers 5ch through 6eh
// - lock flag protects fan registers after start
// - groups 5c-5e, 5f-61, 62-63 are staged
// - groups 64-66, 67-69, 6a-6c, 6d-6e are staged
`timescale 1ns/10ps
module smft_top #(
   parameter int TIMEOUT_CYCLES = smft_pkg::TIMEOUT_CYC,
   parameter int POR_CYCLES = smft_pkg::POR_CYC
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_oe_n_out,
   input wire logic drive3_pin_in,
   output logic drive3_oe_n_out,
   input wire logic fan_speed_in_4,
   input wire logic fan_drive_3_req_in,
   output logic fan_drive_out_3,
   output logic fan_speed_4_valid_out,
   output logic [6:0] target_addr_out,
   output logic addr_latched_out,
   output logic ready_out,
   output logic fan_started_out,
   output logic fan_locked_out,
   output logic [8*smft_pkg::FAN_COUNT-1:0] fan_active_cfg_out
);
   // synchronised pins
   logic scl_s, sda_s, strap_s, sel_s;
   smft_sync u_scl (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .d_in(scl_in), .q_out(scl_s));
   smft_sync u_sda (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .d_in(sda_in), .q_out(sda_s));
   smft_sync u_ae (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .d_in(drive3_pin_in),
      .q_out(strap_s));
   smft_sync u_as (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .d_in(fan_speed_in_4),
      .q_out(sel_s));

   // bus engine state
   smft_pkg::smft_state_type state_reg, state_next;
   logic scl_d_reg, scl_d_next; // previous scl for edges
   logic sda_d_reg, sda_d_next; // previous sda for start/stop
   logic [3:0] bit_cnt_reg, bit_cnt_next; // bit within byte
   logic [7:0] shift_reg, shift_next; // incoming byte
   logic [7:0] ptr_reg, ptr_next; // register pointer
   logic [1:0] byte_idx_reg, byte_idx_next; // byte in transaction: 0 addr, 1 ptr, 2+ data
   logic rd_reg, rd_next; // current transaction is a read
   logic [7:0] tx_reg, tx_next; // outgoing read byte
   logic sda_oe_n_next;
   logic [31:0] low_cnt_reg, low_cnt_next; // stuck-low counter
   // address handling
   logic [6:0] addr_reg, addr_next;
   logic latched_reg, latched_next;
   logic first_done_reg, first_done_next; // first transaction finished
   logic in_txn_reg, in_txn_next; // our transaction in progress
   logic [31:0] por_cnt_reg, por_cnt_next;
   logic ready_next;
   // fan staging
   logic [7:0] stage_mem [smft_pkg::FAN_COUNT];
   logic [7:0] stage_next [smft_pkg::FAN_COUNT];
   logic [7:0] active_mem [smft_pkg::FAN_COUNT];
   logic [7:0] active_next [smft_pkg::FAN_COUNT];
   logic start_reg, start_next;
   logic lock_reg, lock_next;
   logic drive3_next, speed4_next;

   // bus events on synchronised lines
   logic scl_rise, scl_fall, start_cond, stop_cond;
   assign scl_rise = scl_s && !scl_d_reg;
   assign scl_fall = !scl_s && scl_d_reg;
   assign start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   assign stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;

   // address candidate from straps; strap high forces default
   logic [6:0] addr_pick;
   always_comb begin
      if (strap_s) begin
         addr_pick = smft_pkg::ADDR_DEFAULT;
      end else if (sel_s) begin
         addr_pick = smft_pkg::ADDR_SEL_HIGH;
      end else begin
         addr_pick = smft_pkg::ADDR_SEL_LOW;
      end
   end

   // effective compare address: before latch, the strap choice
   logic [6:0] addr_cmp;
   assign addr_cmp = latched_reg ? addr_reg : addr_pick;

   // register read mux
   function automatic logic [7:0] read_byte(input logic [7:0] p);
      logic [7:0] v;
      v = 8'h00;
      if (p == smft_pkg::REG_CTRL) begin
         v = {5'h00, ready_out, lock_reg, start_reg};
      end else if (p >= smft_pkg::FAN_FIRST && p <= smft_pkg::FAN_LAST) begin
         v = stage_mem[5'(p - smft_pkg::FAN_FIRST)];
      end
      return v;
   endfunction

   // next-state logic of bus engine, address latch and fan staging
   always_comb begin
      state_next = state_reg;
      scl_d_next = scl_s;
      sda_d_next = sda_s;
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      ptr_next = ptr_reg;
      byte_idx_next = byte_idx_reg;
      rd_next = rd_reg;
      tx_next = tx_reg;
      sda_oe_n_next = sda_oe_n_out;
      addr_next = addr_reg;
      latched_next = latched_reg;
      first_done_next = first_done_reg;
      in_txn_next = in_txn_reg;
      start_next = start_reg;
      lock_next = lock_reg;
      stage_next = stage_mem;
      active_next = active_mem;
      // stuck-bus counter runs while either line is low
      low_cnt_next = (!scl_s || !sda_s) ? low_cnt_reg + 32'h1 : 32'h0;
      // power-on delay counter
      por_cnt_next = (por_cnt_reg < 32'(POR_CYCLES)) ? por_cnt_reg + 32'h1 : por_cnt_reg;
      ready_next = (por_cnt_reg >= 32'(POR_CYCLES));
      if (!ready_out) begin
         state_next = smft_pkg::SM_IDLE; // engine held until operational
      end else if (low_cnt_reg >= 32'(TIMEOUT_CYCLES)) begin
         state_next = smft_pkg::SM_IDLE;
         sda_oe_n_next = 1'b1;
         in_txn_next = 1'b0;
         low_cnt_next = 32'h0;
      end else if (start_cond) begin
         state_next = smft_pkg::SM_ADDR;
         bit_cnt_next = 4'h0;
         byte_idx_next = 2'h0;
         sda_oe_n_next = 1'b1;
      end else if (stop_cond) begin
         state_next = smft_pkg::SM_IDLE;
         sda_oe_n_next = 1'b1;
         if (in_txn_reg) begin
            first_done_next = 1'b1;
         end
         in_txn_next = 1'b0;
      end else begin
         unique case (state_reg)
            smft_pkg::SM_IDLE: begin
               sda_oe_n_next = 1'b1; // idle: line released
            end
            smft_pkg::SM_ADDR, smft_pkg::SM_DATA: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_s};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
                  // after five address bits, apply late strap change
                  if (state_reg == smft_pkg::SM_ADDR && bit_cnt_reg == 4'h4 && latched_reg && strap_s) begin
                     addr_next = smft_pkg::ADDR_DEFAULT;
                  end
               end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                  bit_cnt_next = 4'h0;
                  if (state_reg == smft_pkg::SM_ADDR) begin
                     // prefix match alone latches the strap choice; only a full match is acked
                     if (shift_reg[7:3] == smft_pkg::ADDR_PREFIX && !latched_reg) begin
                        addr_next = addr_pick;
                        latched_next = 1'b1;
                     end
                     if (shift_reg[7:1] == addr_cmp && shift_reg[7:3] == smft_pkg::ADDR_PREFIX) begin
                        in_txn_next = 1'b1;
                        rd_next = shift_reg[0];
                        tx_next = read_byte(ptr_reg);
                        sda_oe_n_next = 1'b0;
                        state_next = smft_pkg::SM_ACK;
                     end else begin
                        state_next = smft_pkg::SM_IDLE; // not ours
                     end
                  end else begin
                     sda_oe_n_next = 1'b0; // ack data byte
                     state_next = smft_pkg::SM_ACK;
                     if (byte_idx_reg == 2'h1) begin
                        ptr_next = shift_reg;
                     end else if (ptr_reg == smft_pkg::REG_CTRL) begin
                        // control: start and lock are set-only
                        if (shift_reg[smft_pkg::CTRL_START_BIT] && !lock_reg) begin
                           start_next = 1'b1;
                           active_next = stage_mem;
                        end
                        if (shift_reg[smft_pkg::CTRL_LOCK_BIT] && start_reg) begin
                           lock_next = 1'b1;
                        end
                        ptr_next = ptr_reg + 8'h1;
                     end else begin
                        if (ptr_reg >= smft_pkg::FAN_FIRST && ptr_reg <= smft_pkg::FAN_LAST && !lock_reg) begin
                           stage_next[5'(ptr_reg - smft_pkg::FAN_FIRST)] = shift_reg;
                        end
                        ptr_next = ptr_reg + 8'h1;
                     end
                  end
                  if (byte_idx_reg != 2'h3) begin
                     byte_idx_next = byte_idx_reg + 2'h1;
                  end
               end
            end
            smft_pkg::SM_ACK: begin
               // release ack on falling edge, then read or receive
               if (scl_fall) begin
                  if (rd_reg) begin
                     sda_oe_n_next = tx_reg[7];
                     tx_next = {tx_reg[6:0], 1'b1};
                     bit_cnt_next = 4'h1;
                     state_next = smft_pkg::SM_SEND;
                  end else begin
                     sda_oe_n_next = 1'b1;
                     state_next = smft_pkg::SM_DATA;
                  end
               end
            end
            smft_pkg::SM_SEND: begin
               // shift read byte, then watch host ack
               if (scl_fall) begin
                  if (bit_cnt_reg == 4'h8) begin
                     sda_oe_n_next = 1'b1;
                     bit_cnt_next = 4'h9;
                  end else if (bit_cnt_reg == 4'h9) begin
                     ptr_next = ptr_reg + 8'h1;
                     tx_next = read_byte(ptr_reg + 8'h1);
                     state_next = smft_pkg::SM_ACK;
                     sda_oe_n_next = 1'b1;
                  end else begin
                     sda_oe_n_next = tx_reg[7];
                     tx_next = {tx_reg[6:0], 1'b1};
                     bit_cnt_next = bit_cnt_reg + 4'h1;
                  end
               end else if (scl_rise && bit_cnt_reg == 4'h9 && sda_s) begin
                  state_next = smft_pkg::SM_IDLE; // host nack ends read
               end
            end
         endcase
      end
      // shared pins: strap input until first transaction, then fan use at the default address only
      if (!first_done_reg || addr_reg != smft_pkg::ADDR_DEFAULT) begin
         drive3_next = 1'b1;
         speed4_next = 1'b0;
      end else begin
         drive3_next = fan_drive_3_req_in;
         speed4_next = 1'b1;
      end
   end

   // registers of engine, address latch and fan staging, frozen while ce is low
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= smft_pkg::SM_IDLE;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         byte_idx_reg <= 2'h0;
         rd_reg <= 1'b0;
         tx_reg <= 8'hff;
         sda_oe_n_out <= 1'b1;
         low_cnt_reg <= 32'h0;
         addr_reg <= smft_pkg::ADDR_DEFAULT;
         latched_reg <= 1'b0;
         first_done_reg <= 1'b0;
         in_txn_reg <= 1'b0;
         por_cnt_reg <= 32'h0;
         ready_out <= 1'b0;
         start_reg <= 1'b0;
         lock_reg <= 1'b0;
         drive3_oe_n_out <= 1'b1;
         fan_drive_out_3 <= 1'b1;
         fan_speed_4_valid_out <= 1'b0;
         for (int i = 0; i < smft_pkg::FAN_COUNT; i++) begin
            stage_mem[i] <= smft_pkg::FAN_RESET;
            active_mem[i] <= smft_pkg::FAN_RESET;
         end
      end else if (ce_in) begin
         state_reg <= state_next;
         scl_d_reg <= scl_d_next;
         sda_d_reg <= sda_d_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         ptr_reg <= ptr_next;
         byte_idx_reg <= byte_idx_next;
         rd_reg <= rd_next;
         tx_reg <= tx_next;
         sda_oe_n_out <= sda_oe_n_next;
         low_cnt_reg <= low_cnt_next;
         addr_reg <= addr_next;
         latched_reg <= latched_next;
         first_done_reg <= first_done_next;
         in_txn_reg <= in_txn_next;
         por_cnt_reg <= por_cnt_next;
         ready_out <= ready_next;
         start_reg <= start_next;
         lock_reg <= lock_next;
         drive3_oe_n_out <= drive3_next;
         fan_drive_out_3 <= drive3_next;
         fan_speed_4_valid_out <= speed4_next;
         stage_mem <= stage_next;
         active_mem <= active_next;
      end
   end

   // mirrored status outputs, registered copies
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         target_addr_out <= smft_pkg::ADDR_DEFAULT;
         addr_latched_out <= 1'b0;
         fan_started_out <= 1'b0;
         fan_locked_out <= 1'b0;
      end else if (ce_in) begin
         target_addr_out <= addr_next;
         addr_latched_out <= latched_next;
         fan_started_out <= start_next;
         fan_locked_out <= lock_next;
      end
   end

   // active fan config flattened, one slice per entry
   for (genvar g = 0; g < smft_pkg::FAN_COUNT; g++) begin : g_act
      always_ff @(posedge core_clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            fan_active_cfg_out[8*g +: 8] <= smft_pkg::FAN_RESET;
         end else if (ce_in) begin
            fan_active_cfg_out[8*g +: 8] <= active_next[g];
         end
      end
   end
endmodule

// [testbench/smft_monitor.sv]
// checker for the smbus target front end, bound to smft_top
// assumes one core clock domain and the async active-low reset
`timescale 1ns/10ps
module smft_monitor #(
   parameter int TIMEOUT_CYCLES = 200,
   parameter int POR_CYCLES = 20
) (
   input logic core_clk_in,
   input logic rst_n_in,
   input logic scl_in,
   input logic sda_in,
   input logic sda_oe_n_out,
   input logic drive3_pin_in,
   input logic drive3_oe_n_out,
   input logic fan_speed_in_4,
   input logic fan_drive_out_3,
   input logic fan_speed_4_valid_out,
   input logic [6:0] target_addr_out,
   input logic addr_latched_out,
   input logic ready_out,
   input logic fan_started_out,
   input logic fan_locked_out,
   input logic [8*smft_pkg::FAN_COUNT-1:0] fan_active_cfg_out
);
   int low_cnt_reg; // cycles with either bus line low
   int low_cnt_next;
   int por_cnt_reg; // cycles since reset release, saturating
   int por_cnt_next;
   // next values; saturate so long runs never wrap
   always_comb begin
      low_cnt_next = (!scl_in || !sda_in) ? low_cnt_reg + 1 : 0;
      if (low_cnt_next > TIMEOUT_CYCLES + 100) begin
         low_cnt_next = TIMEOUT_CYCLES + 100;
      end
      por_cnt_next = (por_cnt_reg > POR_CYCLES + 10) ? por_cnt_reg : por_cnt_reg + 1;
   end
   // counters only register here
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         low_cnt_reg <= 0;
         por_cnt_reg <= 0;
      end else begin
         low_cnt_reg <= low_cnt_next;
         por_cnt_reg <= por_cnt_next;
      end
   end
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // margin of 8 covers the synchroniser and the output register
   property p_timeout_release;
      (low_cnt_reg > TIMEOUT_CYCLES + 8) |-> sda_oe_n_out;
   endproperty
   a_timeout_release: assert property (p_timeout_release) else $error("sda still pulled after stuck bus");
   property p_ready_in_time;
      (por_cnt_reg > POR_CYCLES + 2) |-> ready_out;
   endproperty
   a_ready_in_time: assert property (p_ready_in_time) else $error("ready late");
   property p_drive3_strap;
      !addr_latched_out |-> drive3_oe_n_out && fan_drive_out_3;
   endproperty
   a_drive3_strap: assert property (p_drive3_strap) else $error("drive 3 pin pulled before first transfer");
   property p_addr_pick;
      $rose(addr_latched_out) |->
         target_addr_out == (drive3_pin_in ? 7'h2e : (fan_speed_in_4 ? 7'h2d : 7'h2c));
   endproperty
   a_addr_pick: assert property (p_addr_pick) else $error("wrong latched address");
   property p_latch_keeps;
      addr_latched_out |=> addr_latched_out;
   endproperty
   a_latch_keeps: assert property (p_latch_keeps) else $error("address latch dropped");
   property p_alt_addr_no_fan;
      addr_latched_out && target_addr_out != 7'h2e |-> !fan_speed_4_valid_out && fan_drive_out_3;
   endproperty
   a_alt_addr_no_fan: assert property (p_alt_addr_no_fan) else $error("fan pins active on other address");
   property p_unstarted_default;
      !fan_started_out |-> fan_active_cfg_out == {smft_pkg::FAN_COUNT{smft_pkg::FAN_RESET}};
   endproperty
   a_unstarted_default: assert property (p_unstarted_default) else $error("staged values applied early");
   property p_lock_freeze;
      fan_locked_out |=> fan_locked_out && $stable(fan_active_cfg_out) && fan_started_out;
   endproperty
   a_lock_freeze: assert property (p_lock_freeze) else $error("locked config changed");
   c_latch: cover property ($rose(addr_latched_out));
   c_lock: cover property ($rose(fan_locked_out));
   c_stuck: cover property (low_cnt_reg > TIMEOUT_CYCLES + 8);
endmodule

// [testbench/smft_host.sv]
// smbus host model: open-drain master stepping on the core clock grid
// assumes the bench forms sda as a wired-and with the device pull-down
`timescale 1ns/10ps
module smft_host (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out
);
   logic bit_seen; // sda level seen at end of scl high
   // both lines released at start
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // wait n core cycles, then step off the edge
   task automatic q(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // 80 ns bit; sda moves two cycles after scl falls, never while high
   task automatic put_bit(input logic b);
      sda_out = b;
      q(2);
      scl_out = 1'b1;
      q(4);
      bit_seen = sda_in;
      scl_out = 1'b0;
      q(2);
   endtask
   task automatic start_bit();
      sda_out = 1'b1;
      scl_out = 1'b1;
      q(4);
      sda_out = 1'b0;
      q(4);
      scl_out = 1'b0;
      q(2);
   endtask
   task automatic stop_bit();
      sda_out = 1'b0;
      q(2);
      scl_out = 1'b1;
      q(4);
      sda_out = 1'b1;
      q(8);
   endtask
   // byte msb first, ninth bit released for the ack
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i]);
      end
      put_bit(1'b1);
      ack = !bit_seen;
   endtask
   // write: address, pointer, one data byte; reports address ack
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ack);
      logic k;
      start_bit();
      send({a, 1'b0}, ack);
      send(p, k);
      send(d, k);
      stop_bit();
   endtask
   // read: address with read bit, one byte from the pointer, then nack
   task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ack);
      start_bit();
      send({a, 1'b1}, ack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1);
         d[i] = bit_seen;
      end
      put_bit(1'b1);
      stop_bit();
   endtask
endmodule

// [testbench/smft_top_tb.sv]
// self-checking bench for smft_top with short timeout and power-on counts
// assumes smft_host as bus master and pulled-up scl/sda
`timescale 1ns/10ps
module smft_top_tb;
   localparam int TO_CYC = 200; // shortened stuck-bus window
   localparam int POR_C = 20; // shortened power-on delay
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic strap = 1'b0; // resistor level on the drive 3 pin
   logic sel = 1'b1; // address-select level
   logic req = 1'b1; // pwm request for drive 3
   logic scl, sda_h, sda_oe_n, d3_oe_n, ack;
   logic [151:0] exp_cfg;
   logic [151:0] cfg;
   logic [6:0] addr;
   logic [7:0] rdat; // byte returned by a read
   logic d3_out, t4_ok, latched, rdy, started, locked;
   int n_errors = 0;
   int checks_done = 0;
   wire logic sda = sda_h & sda_oe_n; // open-drain wired-and
   wire logic d3_pin = strap & d3_oe_n;
   always #5 core_clk_in = ~core_clk_in;
   smft_host smft_host_i (.clk_in(core_clk_in), .sda_in(sda), .scl_out(scl), .sda_out(sda_h));
   smft_top #(.TIMEOUT_CYCLES(TO_CYC), .POR_CYCLES(POR_C)) smft_top_i (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .scl_in(scl), .sda_in(sda),
      .sda_oe_n_out(sda_oe_n), .drive3_pin_in(d3_pin), .drive3_oe_n_out(d3_oe_n), .fan_speed_in_4(sel),
      .fan_drive_3_req_in(req), .fan_drive_out_3(d3_out), .fan_speed_4_valid_out(t4_ok),
      .target_addr_out(addr), .addr_latched_out(latched), .ready_out(rdy), .fan_started_out(started),
      .fan_locked_out(locked), .fan_active_cfg_out(cfg));
   task automatic check(input logic [151:0] seen, input logic [151:0] want);
      checks_done++;
      if (seen !== want) begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, want);
      end
   endtask
   task automatic do_reset();
      rst_n_in = 1'b0;
      repeat (4) @(posedge core_clk_in);
      #1 rst_n_in = 1'b1;
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      do_reset();
      check(d3_oe_n, 1'b1);
      check(rdy, 1'b0);
      repeat (POR_C + 2) @(posedge core_clk_in);
      #1 check(rdy, 1'b1);
      smft_host_i.wr(7'h50, 8'h5c, 8'h00, ack);
      check(ack, 1'b0);
      check(latched, 1'b0);
      // prefix match to a neighbour latches the selected address, no ack
      smft_host_i.wr(7'h2c, 8'h5c, 8'h00, ack);
      check(ack, 1'b0);
      check({latched, addr}, {1'b1, 7'h2d});
      smft_host_i.wr(7'h2d, 8'h5c, 8'h00, ack);
      check(ack, 1'b1);
      req = 1'b0;
      repeat (4) @(posedge core_clk_in);
      #1 check({d3_out, t4_ok}, 2'b10);
      $display("test addressing done");
      // stage all fan registers, nothing applies before start
      for (int i = 0; i < smft_pkg::FAN_COUNT; i++) begin
         exp_cfg[8*i +: 8] = 8'h10 + 8'(i);
         smft_host_i.wr(7'h2d, smft_pkg::FAN_FIRST + 8'(i), 8'h10 + 8'(i), ack);
      end
      check(cfg, '0);
      smft_host_i.wr(7'h2d, 8'h40, 8'h01, ack);
      check(cfg, exp_cfg);
      check(started, 1'b1);
      smft_host_i.wr(7'h2d, 8'h40, 8'h03, ack);
      check(locked, 1'b1);
      smft_host_i.wr(7'h2d, 8'h5c, 8'hff, ack);
      smft_host_i.wr(7'h2d, 8'h40, 8'h01, ack);
      check(cfg, exp_cfg);
      // 5bh is not staged; it only parks the pointer on 5ch for the read
      smft_host_i.wr(7'h2d, 8'h5b, 8'h00, ack);
      smft_host_i.rd(7'h2d, rdat, ack);
      check({ack, rdat}, {1'b1, 8'h10});
      $display("test staging done");
      // strap pulled high late: address flips at the fifth bit, so 2dh is no longer ours
      strap = 1'b1;
      smft_host_i.wr(7'h2d, 8'h40, 8'h00, ack);
      check({ack, addr}, {1'b0, 7'h2e});
      smft_host_i.wr(7'h2e, 8'h40, 8'h00, ack);
      check(ack, 1'b1);
      $display("test revert done");
      // hang scl low during the ack of a matching address
      smft_host_i.start_bit();
      for (int i = 7; i >= 0; i--) begin
         smft_host_i.put_bit(i == 0 ? 1'b0 : 1'(8'h5c >> i));
      end
      repeat (8) @(posedge core_clk_in);
      #1 check(sda_oe_n, 1'b0);
      repeat (TO_CYC + 30) @(posedge core_clk_in);
      #1 check(sda_oe_n, 1'b1);
      smft_host_i.stop_bit();
      smft_host_i.wr(7'h2e, 8'h40, 8'h00, ack);
      check(ack, 1'b1);
      $display("test timeout done");
      // second power-on with default strap, select low
      sel = 1'b0;
      do_reset();
      check({locked, started}, 2'b00);
      repeat (POR_C + 2) @(posedge core_clk_in);
      #1 check(d3_out, 1'b1);
      smft_host_i.wr(7'h2e, 8'h40, 8'h00, ack);
      check({ack, addr}, {1'b1, 7'h2e});
      repeat (4) @(posedge core_clk_in);
      #1 check({d3_out, t4_ok}, 2'b01);
      $display("test default done");
      stop_test();
   end
   // watchdog well beyond the expected run
   initial begin
      #500000;
      n_errors++;
      stop_test();
   end
endmodule
bind smft_top smft_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .POR_CYCLES(POR_CYCLES)) smft_monitor_i (.*);
